/* File: common/smmap_pkg.sv */
// Package holding the address map, field layouts and reset values of the switch host port.
package smmap_pkg;

    localparam int ADDR_W      = 12;
    localparam int DATA_W      = 16;
    localparam int MEM_SEL_BIT = 11;

    // Memory space address fields.
    localparam int STREAM_HI   = 10;
    localparam int STREAM_LO   = 7;
    localparam int CHAN_HI     = 6;
    localparam int CHAN_LO     = 0;

    // Highest usable channel per data rate.
    localparam logic [6:0] CHAN_MAX_2M = 7'h1f;
    localparam logic [6:0] CHAN_MAX_4M = 7'h3f;
    localparam logic [6:0] CHAN_MAX_8M = 7'h7f;

    // Main control register: bits 2..0 select the memory reached in memory space.
    localparam logic [10:0] CTRL_ADDR       = 11'h000;
    localparam logic [15:0] CTRL_RESET      = 16'h0000;
    localparam int          CTRL_MSEL_HI    = 2;
    localparam logic [2:0]  MSEL_CONN       = 3'h1;
    localparam logic [2:0]  MSEL_DATA       = 3'h0;

    // Output offset registers for streams 8 to 15.
    localparam logic [10:0] OOR_BASE_ADDR   = 11'h218;
    localparam int          OOR_COUNT       = 8;
    localparam logic [15:0] OOR_RESET       = 16'h0000;
    localparam logic [15:0] OOR_WMASK       = 16'h0fff;
    localparam int          OCD_HI          = 11;
    localparam int          OCD_LO          = 5;
    localparam int          OBD_HI          = 4;
    localparam int          OBD_LO          = 2;
    localparam int          OFA_HI          = 1;
    localparam int          OFA_LO          = 0;

    // Rate codes per output stream.
    localparam logic [1:0] RATE_2M = 2'h0;
    localparam logic [1:0] RATE_4M = 2'h1;
    localparam logic [1:0] RATE_8M = 2'h2;

    // Connection memory word.
    localparam int CONN_MODE_BIT  = 0;
    localparam int SRC_STREAM_HI  = 11;
    localparam int SRC_STREAM_LO  = 8;
    localparam int SRC_CHAN_HI    = 7;
    localparam int SRC_CHAN_LO    = 1;

    // Memory geometry: 16 streams times 128 channels.
    localparam int MEM_DEPTH      = 2048;
    localparam int MEM_AW         = 11;

endpackage : smmap_pkg

/* File: design/smmap_conn_decode.sv */
// Decoder that splits a connection memory word into mode, source stream and source channel.
`timescale 1ns/1ps
module smmap_conn_decode (
    // Connection word.
    input  wire logic [15:0] conn_word,
    // Decoded fields.
    output logic             special_mode,
    output logic [3:0]       source_stream_field,
    output logic [6:0]       source_channel_field
);
    always_comb begin
        special_mode         = conn_word[smmap_pkg::CONN_MODE_BIT];
        source_stream_field  = conn_word[smmap_pkg::SRC_STREAM_HI:smmap_pkg::SRC_STREAM_LO];
        source_channel_field = conn_word[smmap_pkg::SRC_CHAN_HI:smmap_pkg::SRC_CHAN_LO];
    end
endmodule : smmap_conn_decode

/* File: design/smmap_host_port.sv */
// Host port address decoder, register bank and data or connection memory access.
`timescale 1ns/1ps
// Notes on behaviour
// - Address bit 11 high reaches the memories.
// - Registers decode only with bit 11 low.
// - Control bits 2..0 choose data or connection memory.
// - Bits 10..7 stream, bits 6..0 channel.
// - Channel range follows the stream data rate.
// - Mode bit zero means normal switched connection.
// - Mode bit one means special transmission.
// - Bits 11..8 source stream, 7..1 channel.
// - Offset fields: delay, bit delay, fractional advance.
module smmap_host_port (
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Host bus, one access per cycle while host_cs is high.
    input  wire logic        host_cs,
    input  wire logic        host_we,
    input  wire logic [11:0] host_addr,
    input  wire logic [15:0] host_wdata,
    output logic      [15:0] host_rdata,
    output logic             host_ack,
    output logic             host_range_err,
    // Per-stream data rate for the channel range check.
    input  wire logic [31:0] stream_rate,
    // Switching side lookup of one output channel.
    input  wire logic [10:0] sw_addr,
    output logic             sw_special_mode,
    output logic [3:0]       sw_src_stream,
    output logic [6:0]       sw_src_channel,
    output logic [15:0]      sw_data_word,
    // Output offset fields of stream 8 to 15, selected by index.
    input  wire logic [2:0]  oor_sel,
    output logic [6:0]       out_channel_delay,
    output logic [2:0]       out_bit_delay,
    output logic [1:0]       out_fractional_advance,
    output logic [1:0]       out_advance_quarters
);
    typedef struct packed {
        logic [15:0]                             ctrl;
        logic [smmap_pkg::OOR_COUNT-1:0][15:0]   oor;
        logic [15:0]                             rdata;
        logic                                    ack;
        logic                                    range_err;
        logic                                    sp_mode;
        logic [3:0]                              src_st;
        logic [6:0]                              src_ch;
        logic [15:0]                             dword;
        logic [6:0]                              ocd;
        logic [2:0]                              obd;
        logic [1:0]                              ofa;
        logic [1:0]                              oq;
    } smmap_state_s;

    smmap_state_s state_reg;
    smmap_state_s state_next;

    // Memories stay outside the struct to keep reset cost low; content is undefined at start.
    logic [15:0] data_mem [smmap_pkg::MEM_DEPTH];
    logic [15:0] conn_mem [smmap_pkg::MEM_DEPTH];

    logic        mem_space;
    logic [3:0]  acc_stream;
    logic [6:0]  acc_chan;
    logic [10:0] mem_idx;
    logic        sel_conn;
    logic [1:0]  acc_rate;
    logic        chan_ok;
    logic [6:0]  chan_max;
    logic        dec_special;
    logic [3:0]  dec_stream;
    logic [6:0]  dec_chan;
    logic [15:0] conn_rd;
    logic [15:0] oor_cur;

    assign mem_space  = host_addr[smmap_pkg::MEM_SEL_BIT];
    assign acc_stream = host_addr[smmap_pkg::STREAM_HI:smmap_pkg::STREAM_LO];
    assign acc_chan   = host_addr[smmap_pkg::CHAN_HI:smmap_pkg::CHAN_LO];
    assign mem_idx    = {acc_stream, acc_chan};
    assign sel_conn   = (state_reg.ctrl[smmap_pkg::CTRL_MSEL_HI:0] == smmap_pkg::MSEL_CONN);
    assign acc_rate   = stream_rate[acc_stream*2 +: 2];
    assign conn_rd    = conn_mem[sw_addr];
    assign oor_cur    = state_reg.oor[oor_sel];

    always_comb begin
        case (acc_rate)
            smmap_pkg::RATE_2M: chan_max = smmap_pkg::CHAN_MAX_2M;
            smmap_pkg::RATE_4M: chan_max = smmap_pkg::CHAN_MAX_4M;
            default:            chan_max = smmap_pkg::CHAN_MAX_8M;
        endcase
    end
    assign chan_ok = (acc_chan <= chan_max);

    smmap_conn_decode u_dec (
        .conn_word            (conn_rd),
        .special_mode         (dec_special),
        .source_stream_field  (dec_stream),
        .source_channel_field (dec_chan)
    );

    always_comb begin
        logic [10:0] roff;
        roff = host_addr[10:0] - smmap_pkg::OOR_BASE_ADDR;
        state_next           = state_reg;
        state_next.ack       = host_cs;
        state_next.range_err = 1'b0;
        state_next.rdata     = 16'h0000;
        if (host_cs && mem_space) begin
            state_next.range_err = !chan_ok;
            state_next.rdata     = sel_conn ? conn_mem[mem_idx] : data_mem[mem_idx];
        end else if (host_cs) begin
            if (host_addr[10:0] == smmap_pkg::CTRL_ADDR) begin
                if (host_we) begin
                    state_next.ctrl = host_wdata;
                end
                state_next.rdata = state_reg.ctrl;
            end else if (host_addr[10:0] >= smmap_pkg::OOR_BASE_ADDR &&
                         roff < 11'(smmap_pkg::OOR_COUNT)) begin
                if (host_we) begin
                    state_next.oor[roff[2:0]] = host_wdata & smmap_pkg::OOR_WMASK;
                end
                state_next.rdata = state_reg.oor[roff[2:0]];
            end
        end
        state_next.sp_mode = dec_special;
        state_next.src_st  = dec_special ? 4'h0 : dec_stream;
        state_next.src_ch  = dec_special ? 7'h00 : dec_chan;
        state_next.dword   = data_mem[{dec_stream, dec_chan}];
        state_next.ocd     = oor_cur[smmap_pkg::OCD_HI:smmap_pkg::OCD_LO];
        state_next.obd     = oor_cur[smmap_pkg::OBD_HI:smmap_pkg::OBD_LO];
        state_next.ofa     = oor_cur[smmap_pkg::OFA_HI:smmap_pkg::OFA_LO];
        // Code 0 advances nothing; codes 1..3 map to 1..3 quarter bits.
        state_next.oq      = oor_cur[smmap_pkg::OFA_HI:smmap_pkg::OFA_LO];
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg       <= '0;
            state_reg.ctrl  <= smmap_pkg::CTRL_RESET;
            for (int i = 0; i < smmap_pkg::OOR_COUNT; i++) begin
                state_reg.oor[i] <= smmap_pkg::OOR_RESET;
            end
        end else begin
            state_reg <= state_next;
        end
    end

    // Memory writes; the host is the only writer of both memories, and a channel out of range is not written.
    always_ff @(posedge mclk) begin
        if (rst_n && host_cs && host_we && mem_space && chan_ok) begin
            if (sel_conn) begin
                conn_mem[mem_idx] <= host_wdata;
            end else begin
                data_mem[mem_idx] <= host_wdata;
            end
        end
    end

    assign host_rdata             = state_reg.rdata;
    assign host_ack               = state_reg.ack;
    assign host_range_err         = state_reg.range_err;
    assign sw_special_mode        = state_reg.sp_mode;
    assign sw_src_stream          = state_reg.src_st;
    assign sw_src_channel         = state_reg.src_ch;
    assign sw_data_word           = state_reg.dword;
    assign out_channel_delay      = state_reg.ocd;
    assign out_bit_delay          = state_reg.obd;
    assign out_fractional_advance = state_reg.ofa;
    assign out_advance_quarters   = state_reg.oq;
endmodule : smmap_host_port

/* File: dv/smmap_host_port_properties.sv */
// Checker of host port answer timing and field decoding.
`timescale 1ns/1ps
module smmap_props (
    // Clock, reset and host bus.
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic host_cs,
    input wire logic host_we,
    input wire logic [11:0] host_addr,
    input wire logic [15:0] host_rdata,
    input wire logic host_ack,
    input wire logic host_range_err,
    input wire logic [31:0] stream_rate,
    // Switching side and offset fields.
    input wire logic sw_special_mode,
    input wire logic [3:0] sw_src_stream,
    input wire logic [6:0] sw_src_channel,
    input wire logic [1:0] out_fractional_advance,
    input wire logic [1:0] out_advance_quarters
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire logic [1:0] rate = stream_rate[{host_addr[10:7], 1'b0} +: 2];
    wire logic mw = host_cs && host_we && host_addr[11];
    property p_ack; host_cs |=> host_ack; endproperty
    a_ack: assert property (p_ack) else $error("no ack after access");
    property p_idle; !host_cs |=> !host_ack; endproperty
    a_idle: assert property (p_idle) else $error("ack without access");
    property p_unmap; host_cs && !host_we && host_addr[11:8] == 4'h1 |=> host_rdata == 16'h0000;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_lo; host_cs && host_addr[11] && host_addr[6:0] <= 7'h1f |=> !host_range_err;
    endproperty
    a_lo: assert property (p_lo) else $error("low channel flagged");
    property p_2m; mw && rate == 2'h0 && host_addr[6:5] != 2'h0 |=> host_range_err; endproperty
    a_2m: assert property (p_2m) else $error("slow stream range missed");
    property p_4m; mw && rate == 2'h1 && host_addr[6] |=> host_range_err; endproperty
    a_4m: assert property (p_4m) else $error("middle stream range missed");
    property p_spec; sw_special_mode |-> sw_src_stream == 4'h0 && sw_src_channel == 7'h00;
    endproperty
    a_spec: assert property (p_spec) else $error("special word shows a source");
    property p_quart; out_advance_quarters == out_fractional_advance; endproperty
    a_quart: assert property (p_quart) else $error("advance quarters wrong");
    cover property (host_range_err);
    cover property (sw_special_mode);
    cover property (host_cs && host_addr[11] ##1 host_ack);
endmodule : smmap_props
bind smmap_host_port smmap_props u_props (.mclk(mclk), .rst_n(rst_n), .host_cs(host_cs),
    .host_we(host_we), .host_addr(host_addr), .host_rdata(host_rdata), .host_ack(host_ack),
    .host_range_err(host_range_err), .stream_rate(stream_rate), .sw_special_mode(sw_special_mode),
    .sw_src_stream(sw_src_stream), .sw_src_channel(sw_src_channel),
    .out_fractional_advance(out_fractional_advance), .out_advance_quarters(out_advance_quarters));

/* File: dv/smmap_host_model.sv */
// Host processor model issuing single accesses on the host port.
`timescale 1ns/1ps
module smmap_host_model (
    // Clock.
    input wire logic mclk,
    // Host bus.
    output logic host_cs = 1'b0,
    output logic host_we = 1'b0,
    output logic [11:0] host_addr = 12'h000,
    output logic [15:0] host_wdata = 16'h0000,
    input wire logic [15:0] host_rdata,
    input wire logic host_ack,
    input wire logic host_range_err
);
    // Address and write data are inverted on release and cs drops, so a stale value never looks like a request.
    // The answer stands for one cycle only, so it is taken just after the edge that takes cs.
    task automatic acc(input logic w, input logic [11:0] a, input logic [15:0] d,
                       output logic [15:0] q, output logic e, output logic ak);
        @(posedge mclk);
        host_cs <= 1'b1;
        host_we <= w;
        host_addr <= a;
        host_wdata <= d;
        @(posedge mclk);
        host_cs <= 1'b0;
        host_addr <= ~a;
        host_wdata <= ~d;
        #1;
        q = host_rdata;
        e = host_range_err;
        ak = host_ack;
    endtask : acc
endmodule : smmap_host_model

/* File: dv/smmap_host_port_tb_top.sv */
// Testbench top for the switch host port.
`timescale 1ns/1ps
module smmap_host_port_tb_top;
    logic mclk = 1'b0, rst_n = 1'b0, cs, we, ack, err, spec, e, a;
    logic [31:0] stream_rate = 32'h0000_0100;
    logic [10:0] sw_addr = 11'h000;
    logic [2:0] oor_sel = 3'h0, bd;
    logic [11:0] addr;
    logic [15:0] wd, rd, q, dword, v;
    logic [3:0] ss;
    logic [6:0] sc, cd;
    logic [1:0] fa, aq;
    int bad_count = 0, total_checks = 0;
    initial begin
        forever #5 mclk = ~mclk;
    end
    smmap_host_model host_u (.mclk(mclk), .host_cs(cs), .host_we(we), .host_addr(addr),
        .host_wdata(wd), .host_rdata(rd), .host_ack(ack), .host_range_err(err));
    smmap_host_port dut_u (.mclk(mclk), .rst_n(rst_n), .host_cs(cs), .host_we(we),
        .host_addr(addr), .host_wdata(wd), .host_rdata(rd), .host_ack(ack),
        .host_range_err(err), .stream_rate(stream_rate), .sw_addr(sw_addr),
        .sw_special_mode(spec), .sw_src_stream(ss), .sw_src_channel(sc), .sw_data_word(dword),
        .oor_sel(oor_sel), .out_channel_delay(cd), .out_bit_delay(bd),
        .out_fractional_advance(fa), .out_advance_quarters(aq));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask : chk
    task automatic io(input logic w, input logic [11:0] ad, input logic [15:0] d);
        host_u.acc(w, ad, d, q, e, a);
        chk({15'h0, a}, 16'h0001);
    endtask : io
    task automatic t_regs();
        io(1'b0, 12'h000, 16'h0);
        chk(q, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            v = {4'h0, 7'(3 * i), 3'(i), 2'(i)};
            io(1'b0, 12'h218 + 12'(i), 16'h0);
            chk(q, 16'h0000);
            io(1'b1, 12'h218 + 12'(i), v | 16'hf000);
            io(1'b0, 12'h218 + 12'(i), 16'h0);
            chk(q, v);
            @(posedge mclk);
            oor_sel <= 3'(i);
            repeat (2) @(posedge mclk);
            #1;
            chk({4'h0, cd, bd, fa}, v);
            chk({14'h0, aq}, {14'h0, 2'(i)});
        end
        $display("t_regs done");
    endtask : t_regs
    task automatic t_mem();
        io(1'b1, 12'h000, 16'h0000);
        io(1'b1, 12'hc85, 16'h1234);
        io(1'b0, 12'hc85, 16'h0);
        chk(q, 16'h1234);
        io(1'b1, 12'h000, 16'h0001);
        io(1'b1, 12'h907, 16'h090a);
        io(1'b0, 12'h907, 16'h0);
        chk(q, 16'h090a);
        @(posedge mclk);
        sw_addr <= 11'h107;
        repeat (3) @(posedge mclk);
        #1;
        chk({spec, 4'h0, ss, sc}, 16'h0485);
        chk(dword, 16'h1234);
        io(1'b1, 12'h907, 16'h090b);
        repeat (3) @(posedge mclk);
        #1;
        chk({spec, 15'h0}, 16'h8000);
        $display("t_mem done");
    endtask : t_mem
    task automatic t_range();
        logic [11:0] ta [4] = '{12'h9a0, 12'h99f, 12'ha40, 12'ha3f};
        io(1'b1, 12'h000, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            io(1'b1, ta[i], 16'h5a5a);
            chk({15'h0, e}, {15'h0, ~i[0]});
        end
        io(1'b0, 12'ha3f, 16'h0);
        chk(q, 16'h5a5a);
        io(1'b0, 12'h100, 16'h0);
        chk(q, 16'h0000);
        $display("t_range done");
    endtask : t_range
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        t_regs();
        t_mem();
        t_range();
        close_out();
    end
    initial begin
        repeat (3000) @(posedge mclk);
        bad_count++;
        close_out();
    end
endmodule : smmap_host_port_tb_top
